// >>> verilog/hbpwm_top.sv
/*
  Five-output pulse-width modulator with standard and H-bridge modes,
  a plain register port, trip input and external realign input.
  Assumes all inputs are synchronous to clk_in; the bridge output table in
  H-bridge mode is the common enable/direction steering described below.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - Five outputs, reset into bridge mode
// - Two pairs and one single output, own periods and duties
// - Prescaler divides clock by 2 to 256
// - Sixteen-bit timer compared, length sets period
// - Output zero rises compare0, falls compare1
// - Output one rises length, falls compare2/high
// - Pair one behaves like pair zero
// - Output four own compares and length
// - Realign falling edge resets counters when enabled
// - Bits 12 and 11 invert outputs three, one
// - Trip low clears enable, raises interrupt
// - Bridge enable acts only in bridge mode
// - Bit five inverts all outputs
// - High-side-off forces highs up, lows down
// - Shadow compares load on 0 to 1 step
// - Direction selects which pair drives
// - Mode select and global enable bits
module hbpwm_top
  import hbpwm_pkg::*;
(
  input  wire logic                         clk_in,
  input  wire logic                         reset_in,
  input  wire logic [hbpwm_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [31:0]                  wdata_in,
  input  wire logic                         wr_in,
  input  wire logic                         rd_in,
  output logic      [31:0]                  rdata_out,
  input  wire logic                         trip_input_pin_in,
  input  wire logic                         realign_in,
  output logic      [4:0]                   pwm_out,
  output logic                              irq_out
);
  import hbpwm_pkg::*;

  logic [15:0] modulator_control;
  logic [15:0] cmp_reg [0:7];
  logic [15:0] cmp_int [0:7];
  logic [15:0] len_reg [0:2];
  logic [15:0] count   [0:2];
  logic [4:0]  raw;
  logic [4:0]  next_pwm;
  logic        tick;
  logic        realign_prev;
  logic        realign_fall;
  logic        load_pend;
  logic [15:0] wd;
  logic [15:0] rd_mux;

  assign wd = wdata_in[15:0];

  hbpwm_prescale u_pre (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .code_in  (modulator_control[BIT_CP_LO +: CP_W]),
    .clear_in (realign_fall),
    .tick_out (tick)
  );

  // Realign edge is seen in the same cycle the pin falls; timers clear on the next edge
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      realign_prev <= 1'b1;
    end else begin
      realign_prev <= realign_in;
    end
  end
  assign realign_fall = modulator_control[BIT_SYNC] && realign_prev && !realign_in;

  // Control register; trip clears the global enable and wins over a write
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      modulator_control <= CON_RESET;
    end else begin
      if (wr_in && addr_in == OFS_CON) begin
        modulator_control <= wd & CON_WMASK;
      end
      if (modulator_control[BIT_TRIP] && !trip_input_pin_in) begin
        modulator_control[BIT_EN] <= 1'b0;
      end
    end
  end

  // Compare index: pair0 0..2, pair1 3..5, single 6..7
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 8; i++) begin
        cmp_reg[i] <= REG_RESET;
      end
      for (int i = 0; i < 3; i++) begin
        len_reg[i] <= LEN_RESET;
      end
    end else if (wr_in) begin
      case (addr_in)
        OFS_P0C0: cmp_reg[0] <= wd;
        OFS_P0C1: cmp_reg[1] <= wd;
        OFS_P0C2: cmp_reg[2] <= wd;
        OFS_P1C0: cmp_reg[3] <= wd;
        OFS_P1C1: cmp_reg[4] <= wd;
        OFS_P1C2: cmp_reg[5] <= wd;
        OFS_S_CA: cmp_reg[6] <= wd;
        OFS_S_CB: cmp_reg[7] <= wd;
        OFS_P0LN: len_reg[0] <= wd;
        OFS_P1LN: len_reg[1] <= wd;
        OFS_S_LN: len_reg[2] <= wd;
        default: ;
      endcase
    end
  end

  // Three independent timers, one per pair and one for the single output
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_tmr
      always_ff @(posedge clk_in) begin
        if (reset_in || realign_fall) begin
          count[g] <= CNT_ZERO;
        end else if (tick) begin
          if (count[g] >= len_reg[g]) begin
            count[g] <= CNT_ZERO;
          end else begin
            count[g] <= count[g] + CNT_ONE;
          end
        end
      end
    end
  endgenerate

  // Shadow load uses pair-zero timer step 0 -> 1 so all channels update together
  assign load_pend = tick && count[0] == CNT_ZERO && len_reg[0] != CNT_ZERO;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 8; i++) begin
        cmp_int[i] <= REG_RESET;
      end
    end else if (modulator_control[BIT_LOAD] && load_pend) begin
      for (int i = 0; i < 8; i++) begin
        cmp_int[i] <= cmp_reg[i];
      end
    end
  end

  // Raw waveforms; edges act on the tick where the count matches
  generate
    for (g = 0; g < 2; g++) begin : g_pair
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          raw[2*g]   <= 1'b0;
          raw[2*g+1] <= 1'b0;
        end else if (tick) begin
          if (count[g] == cmp_int[3*g]) begin
            raw[2*g] <= 1'b1;
          end else if (count[g] == cmp_int[3*g+1]) begin
            raw[2*g] <= 1'b0;
          end
          if (count[g] == len_reg[g]) begin
            raw[2*g+1] <= 1'b1;
          end else if (count[g] == cmp_int[3*g+2] ||
                       (raw[2*g] && count[g] == cmp_int[3*g+1])) begin
            raw[2*g+1] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      raw[4] <= 1'b0;
    end else if (tick) begin
      if (count[2] == cmp_int[6]) begin
        raw[4] <= 1'b1;
      end else if (count[2] == cmp_int[7]) begin
        raw[4] <= 1'b0;
      end
    end
  end

  // Output steering; bridge table: off -> all low, high-side-off -> highs up
  always_comb begin
    next_pwm    = raw;
    next_pwm[1] = raw[1] ^ modulator_control[BIT_INV1];
    next_pwm[3] = raw[3] ^ modulator_control[BIT_INV3];
    if (modulator_control[BIT_BRIDGE_MODE_SELECT]) begin
      if (modulator_control[BIT_HIGH_SIDE_OFF]) begin
        next_pwm[3:0] = 4'h5;
      end else if (!modulator_control[BIT_BEN]) begin
        next_pwm[3:0] = 4'h0;
      end else if (modulator_control[BIT_DIR]) begin
        next_pwm[3:2] = 2'h0;
      end else begin
        next_pwm[1:0] = 2'h0;
      end
    end else if (modulator_control[BIT_HIGH_SIDE_OFF]) begin
      next_pwm[3:0] = 4'h5;
    end
    if (!modulator_control[BIT_EN]) begin
      next_pwm = 5'h00;
    end
    if (modulator_control[BIT_INV]) begin
      next_pwm = ~next_pwm;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pwm_out <= 5'h00;
    end else begin
      pwm_out <= next_pwm;
    end
  end

  // Trip interrupt is sticky; a new trip in the clear cycle keeps it set
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else if (modulator_control[BIT_TRIP] && !trip_input_pin_in) begin
      irq_out <= 1'b1;
    end else if (wr_in && addr_in == OFS_ICLR) begin
      irq_out <= 1'b0;
    end
  end

  always_comb begin
    case (addr_in)
      OFS_CON:  rd_mux = modulator_control;
      OFS_P0C0: rd_mux = cmp_reg[0];
      OFS_P0C1: rd_mux = cmp_reg[1];
      OFS_P0C2: rd_mux = cmp_reg[2];
      OFS_P0LN: rd_mux = len_reg[0];
      OFS_P1C0: rd_mux = cmp_reg[3];
      OFS_P1C1: rd_mux = cmp_reg[4];
      OFS_P1C2: rd_mux = cmp_reg[5];
      OFS_P1LN: rd_mux = len_reg[1];
      OFS_S_CA: rd_mux = cmp_reg[6];
      OFS_S_CB: rd_mux = cmp_reg[7];
      OFS_S_LN: rd_mux = len_reg[2];
      default:  rd_mux = REG_RESET;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      rdata_out <= {16'h0000, rd_mux};
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

  AST_RESET_MODE: assert property (@(posedge clk_in)
    reset_in |=> modulator_control == CON_RESET)
    else $error("control not at reset value");

  AST_TRIP_CLEARS: assert property (@(posedge clk_in) disable iff (reset_in)
    (modulator_control[BIT_TRIP] && !trip_input_pin_in) |=> !modulator_control[BIT_EN] && irq_out)
    else $error("trip did not clear enable");

  AST_ICLR: assert property (@(posedge clk_in) disable iff (reset_in)
    (wr_in && addr_in == OFS_ICLR && !(modulator_control[BIT_TRIP] && !trip_input_pin_in))
      |=> !irq_out)
    else $error("interrupt clear ignored");

  AST_REALIGN: assert property (@(posedge clk_in) disable iff (reset_in)
    realign_fall |=> count[0] == CNT_ZERO && count[1] == CNT_ZERO && count[2] == CNT_ZERO)
    else $error("realign did not reset timers");

  AST_DISABLED: assert property (@(posedge clk_in) disable iff (reset_in)
    (!modulator_control[BIT_EN] && !modulator_control[BIT_INV]) |=> pwm_out == 5'h00)
    else $error("outputs active while disabled");

  AST_HIGH_SIDE_OFF: assert property (@(posedge clk_in) disable iff (reset_in)
    (modulator_control[BIT_EN] && modulator_control[BIT_HIGH_SIDE_OFF] && !modulator_control[BIT_INV])
      |=> pwm_out[3:0] == 4'h5)
    else $error("high-side-off pattern wrong");

  AST_DIR: assert property (@(posedge clk_in) disable iff (reset_in)
    (modulator_control[BIT_BRIDGE_MODE_SELECT] && !modulator_control[BIT_HIGH_SIDE_OFF] && !modulator_control[BIT_INV]
     && modulator_control[BIT_DIR]) |=> pwm_out[3:2] == 2'h0)
    else $error("direction did not hold pair one low");

  AST_WRAP: assert property (@(posedge clk_in) disable iff (reset_in || realign_fall)
    (tick && count[0] >= len_reg[0]) |=> count[0] == CNT_ZERO)
    else $error("timer did not wrap at length");

  sequence s_load_step;
    modulator_control[BIT_LOAD] && load_pend;
  endsequence
  AST_SHADOW: assert property (@(posedge clk_in) disable iff (reset_in)
    s_load_step |=> cmp_int[0] == $past(cmp_reg[0]))
    else $error("shadow compare not loaded");

  AST_INV: assert property (@(posedge clk_in) disable iff (reset_in)
    (modulator_control[BIT_INV] && !modulator_control[BIT_EN]) |=> pwm_out == 5'h1F)
    else $error("global invert missing");

  // Pair and single-channel edges land one clock after the matching tick
  sequence s_p0_rise;
    tick && count[0] == cmp_int[0];
  endsequence

  sequence s_p0_fall;
    tick && count[0] != cmp_int[0] && count[0] == cmp_int[1];
  endsequence

  AST_P0_RISE: assert property (@(posedge clk_in) disable iff (reset_in)
    s_p0_rise |=> raw[0])
    else $error("output zero missed its rise");

  AST_P0_FALL: assert property (@(posedge clk_in) disable iff (reset_in)
    s_p0_fall |=> !raw[0])
    else $error("output zero missed its fall");

  AST_P0_LOW_RISE: assert property (@(posedge clk_in) disable iff (reset_in)
    (tick && count[0] == len_reg[0]) |=> raw[1])
    else $error("output one missed its rise");

  AST_P0_LOW_FALL: assert property (@(posedge clk_in) disable iff (reset_in)
    (tick && count[0] != len_reg[0] && count[0] == cmp_int[2]) |=> !raw[1])
    else $error("output one missed its fall");

  AST_P1_RISE: assert property (@(posedge clk_in) disable iff (reset_in)
    (tick && count[1] == cmp_int[3]) |=> raw[2])
    else $error("output two missed its rise");

  AST_SINGLE_RISE: assert property (@(posedge clk_in) disable iff (reset_in)
    (tick && count[2] == cmp_int[6]) |=> raw[4])
    else $error("output four missed its rise");

  AST_BRIDGE_OFF: assert property (@(posedge clk_in) disable iff (reset_in)
    (modulator_control[BIT_BRIDGE_MODE_SELECT] && !modulator_control[BIT_HIGH_SIDE_OFF] && !modulator_control[BIT_BEN]
     && !modulator_control[BIT_INV]) |=> pwm_out[3:0] == 4'h0)
    else $error("bridge outputs active with bridge enable clear");

  AST_INV1: assert property (@(posedge clk_in) disable iff (reset_in)
    (modulator_control[BIT_EN] && !modulator_control[BIT_BRIDGE_MODE_SELECT] && !modulator_control[BIT_HIGH_SIDE_OFF]
     && !modulator_control[BIT_INV])
      |=> pwm_out[1] == ($past(raw[1]) ^ $past(modulator_control[BIT_INV1])))
    else $error("output one polarity wrong");

  // Fastest prescale code must tick every second clock
  sequence s_tick_fast;
    (tick && modulator_control[BIT_CP_LO +: CP_W] == '0 && !realign_fall)
      ##1 (modulator_control[BIT_CP_LO +: CP_W] == '0 && !realign_fall);
  endsequence

  AST_TICK_FAST: assert property (@(posedge clk_in) disable iff (reset_in)
    s_tick_fast |=> tick)
    else $error("prescaler tick late at divide by two");
endmodule // hbpwm_top

// >>> verilog/hbpwm_pkg.sv
/*
  Constants shared by the H-bridge modulator: register offsets, control bit
  positions, reset values and prescaler code and divider widths.
  Assumes a 32-bit register port with one aligned word per register.
*/
package hbpwm_pkg;
  localparam int          ADDR_W   = 32;
  localparam int          DATA_W   = 16;
  localparam logic [31:0] OFS_CON  = 32'hFFFF0F80;
  localparam logic [31:0] OFS_P0C0 = 32'hFFFF0F84;
  localparam logic [31:0] OFS_P0C1 = 32'hFFFF0F88;
  localparam logic [31:0] OFS_P0C2 = 32'hFFFF0F8C;
  localparam logic [31:0] OFS_P0LN = 32'hFFFF0F90;
  localparam logic [31:0] OFS_P1C0 = 32'hFFFF0F94;
  localparam logic [31:0] OFS_P1C1 = 32'hFFFF0F98;
  localparam logic [31:0] OFS_P1C2 = 32'hFFFF0F9C;
  localparam logic [31:0] OFS_P1LN = 32'hFFFF0FA0;
  localparam logic [31:0] OFS_S_CA = 32'hFFFF0FA4;
  localparam logic [31:0] OFS_S_CB = 32'hFFFF0FA8;
  localparam logic [31:0] OFS_S_LN = 32'hFFFF0FAC;
  localparam logic [31:0] OFS_ICLR = 32'hFFFF0FB8;
  localparam logic [15:0] CON_RESET  = 16'h0012;
  localparam logic [15:0] CON_WMASK  = 16'h5FFF;
  localparam logic [15:0] REG_RESET  = 16'h0000;
  localparam logic [15:0] LEN_RESET  = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam int BIT_EN    = 0;
  localparam int BIT_BRIDGE_MODE_SELECT = 1;
  localparam int BIT_DIR   = 2;
  localparam int BIT_LOAD  = 3;
  localparam int BIT_HIGH_SIDE_OFF  = 4;
  localparam int BIT_INV   = 5;
  localparam int BIT_CP_LO = 6;
  localparam int BIT_BEN   = 9;
  localparam int BIT_TRIP  = 10;
  localparam int BIT_INV1  = 11;
  localparam int BIT_INV3  = 12;
  localparam int BIT_SYNC  = 14;
  localparam int CP_W      = 3;
  localparam int DIV_W     = 8;
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
endpackage

// >>> verilog/hbpwm_prescale.sv
/*
  Prescaler: a one-cycle tick every 2^(code+1) clocks of the system clock.
  Assumes the system clock is the undivided clock and reset is synchronous.
*/
`timescale 1ns/1ns
module hbpwm_prescale
  import hbpwm_pkg::*;
(
  input  wire logic                       clk_in,
  input  wire logic                       reset_in,
  input  wire logic [hbpwm_pkg::CP_W-1:0] code_in,
  input  wire logic                       clear_in,
  output logic                            tick_out
);
  import hbpwm_pkg::*;

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] limit;

  assign limit = DIV_W'((9'h002 << code_in) - 9'h001);

  always_ff @(posedge clk_in) begin
    if (reset_in || clear_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else if (count >= limit) begin
      count    <= '0;
      tick_out <= 1'b1;
    end else begin
      count    <= count + DIV_ONE;
      tick_out <= 1'b0;
    end
  end
endmodule // hbpwm_prescale

// >>> sim/hbpwm_stage_model.sv
/*
  Power-stage model: watches modulator outputs 0 to 3 as a bridge would.
  Assumes outputs 0/1 and 2/3 are the two driven pairs of one full bridge.
*/
`timescale 1ns/1ns
module hbpwm_stage_model (
  input  wire logic       clk_in,
  input  wire logic [4:0] pwm_in,
  input  wire logic       clear_in,
  output logic            short_out
);
  // Both diagonals on together would short the supply; sticky until cleared
  always_ff @(posedge clk_in) begin
    if (clear_in) begin
      short_out <= 1'b0;
    end else if (pwm_in[0] & pwm_in[3] & pwm_in[2] & pwm_in[1]) begin
      short_out <= 1'b1;
    end
  end
endmodule // hbpwm_stage_model

// >>> sim/tb_top.sv
/*
  Bench for the modulator: registers, waveforms, modes, prescaler, trip.
  Assumes the stage model is compiled before this file.
*/
`timescale 1ns/1ns
module tb_top;
  import hbpwm_pkg::*;
  logic        clk_in     = 1'b0;
  logic        reset_in   = 1'b1;
  logic [31:0] addr_in    = '0;
  logic [31:0] wdata_in   = '0;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic        trip_pin_n = 1'b1;
  logic        realign_in = 1'b1;
  logic        stage_clr  = 1'b1;
  logic [31:0] rdata_out;
  logic [4:0]  pwm_out;
  logic        irq_out;
  logic        short_out;
  logic [31:0] rv;
  logic [15:0] hc [5];
  logic [39:0] tbl_exp [12];
  logic [15:0] tbl_con [12];
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc        = 0;

  hbpwm_top hbpwm_top_inst (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .trip_input_pin_in(trip_pin_n), .realign_in(realign_in), .pwm_out(pwm_out),
    .irq_out(irq_out));
  hbpwm_stage_model hbpwm_stage_model_inst (.clk_in(clk_in), .pwm_in(pwm_out),
    .clear_in(stage_clr), .short_out(short_out));

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  // Longest test is the div-256 prescaler pass; ceiling leaves ample margin
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= {16'h0000, d};
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    rv = rdata_out;
  endtask

  // High-cycle count of every output over n clocks; expected bytes scaled by 2^sh
  task automatic duty(input int n, input logic [39:0] e, input int sh);
    for (int i = 0; i < 5; i++) hc[i] = '0;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      for (int i = 0; i < 5; i++) hc[i] = hc[i] + pwm_out[i];
    end
    for (int i = 0; i < 5; i++) chk({16'h0000, hc[i]}, {24'h0, e[8*i +: 8]} << sh, "duty");
  endtask

  task automatic t_reset();
    rd(OFS_CON);
    chk(rv, 32'h00000012, "control reset");
    rd(OFS_P0C0);
    chk(rv, 32'h00000000, "compare reset");
    rd(OFS_P0LN);
    chk(rv, 32'h0000FFFF, "length reset");
    chk({27'h0, pwm_out}, 32'h0, "outputs at reset");
    chk({31'h0, irq_out}, 32'h0, "irq at reset");
    $display("test reset done");
  endtask

  task automatic t_regs();
    wr(OFS_CON, 16'hFFFF);
    rd(OFS_CON);
    chk(rv, 32'h00005FFF, "reserved bits");
    wr(32'hFFFF0FB4, 16'h1234);
    rd(32'hFFFF0FB4);
    chk(rv, 32'h00000000, "unmapped");
    wr(OFS_P1C2, 16'hA5A5);
    rd(OFS_P1C2);
    chk(rv, 32'h0000A5A5, "compare rw");
    $display("test registers done");
  endtask

  // Short periods; realign restarts the timers so the first rise of output zero is timed
  task automatic t_setup();
    wr(OFS_P0LN, 16'h0003);
    wr(OFS_P0C0, 16'h0001);
    wr(OFS_P0C1, 16'h0002);
    wr(OFS_P0C2, 16'h0000);
    wr(OFS_P1LN, 16'h0007);
    wr(OFS_P1C0, 16'h0002);
    wr(OFS_P1C1, 16'h0006);
    wr(OFS_P1C2, 16'h0000);
    wr(OFS_S_LN, 16'h0001);
    wr(OFS_S_CA, 16'h0000);
    wr(OFS_S_CB, 16'h0001);
    wr(OFS_CON, 16'h4009);
    realign_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    realign_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    chk({31'h0, pwm_out[0]}, 32'h1, "realign rise");
    repeat (2) @(posedge clk_in);
    #1;
    chk({31'h0, pwm_out[0]}, 32'h0, "realign fall");
    repeat (40) @(posedge clk_in);
    duty(32, {8'd16, 8'd4, 8'd16, 8'd8, 8'd8}, 0);
    $display("test waveform done");
  endtask

  task automatic t_shadow();
    wr(OFS_CON, 16'h4001);
    wr(OFS_P0C1, 16'h0003);
    repeat (32) @(posedge clk_in);
    duty(32, {8'd16, 8'd4, 8'd16, 8'd8, 8'd8}, 0);
    wr(OFS_CON, 16'h4009);
    repeat (32) @(posedge clk_in);
    duty(32, {8'd16, 8'd4, 8'd16, 8'd8, 8'd16}, 0);
    wr(OFS_P0C1, 16'h0002);
    $display("test shadow done");
  endtask

  task automatic t_modes();
    tbl_con = '{16'h4009, 16'h4809, 16'h5009, 16'h4029, 16'h4019, 16'h420D,
                16'h420F, 16'h420B, 16'h400B, 16'h401B, 16'h4008, 16'h4028};
    tbl_exp = '{{8'd16, 8'd4, 8'd16, 8'd8, 8'd8}, {8'd16, 8'd4, 8'd16, 8'd24, 8'd8},
                {8'd16, 8'd28, 8'd16, 8'd8, 8'd8}, {8'd16, 8'd28, 8'd16, 8'd24, 8'd24},
                {8'd16, 8'd0, 8'd32, 8'd0, 8'd32}, {8'd16, 8'd4, 8'd16, 8'd8, 8'd8},
                {8'd16, 8'd0, 8'd0, 8'd8, 8'd8}, {8'd16, 8'd4, 8'd16, 8'd0, 8'd0},
                {8'd16, 8'd0, 8'd0, 8'd0, 8'd0}, {8'd16, 8'd0, 8'd32, 8'd0, 8'd32},
                {8'd0, 8'd0, 8'd0, 8'd0, 8'd0}, {8'd32, 8'd32, 8'd32, 8'd32, 8'd32}};
    for (int r = 0; r < 12; r++) begin
      wr(OFS_CON, tbl_con[r]);
      repeat (32) @(posedge clk_in);
      stage_clr <= 1'b1;
      @(posedge clk_in);
      stage_clr <= 1'b0;
      duty(32, tbl_exp[r], 0);
      if (r >= 6 && r <= 9) chk({31'h0, short_out}, 32'h0, "bridge short");
    end
    $display("test modes done");
  endtask

  task automatic t_scale();
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CON, 16'h4009 | (16'(c) << 6));
      repeat (16 << (c + 1)) @(posedge clk_in);
      duty(16 << (c + 1), {8'd8, 8'd2, 8'd8, 8'd4, 8'd4}, c + 1);
    end
    $display("test prescaler done");
  endtask

  task automatic t_trip();
    wr(OFS_CON, 16'h4009);
    trip_pin_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    trip_pin_n <= 1'b1;
    #1;
    chk({31'h0, irq_out}, 32'h0, "trip masked");
    wr(OFS_CON, 16'h4409);
    trip_pin_n <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    chk({31'h0, irq_out}, 32'h1, "trip irq");
    rd(OFS_CON);
    chk(rv, 32'h00004408, "trip enable");
    chk({27'h0, pwm_out}, 32'h0, "trip outputs");
    wr(OFS_ICLR, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1;
    chk({31'h0, irq_out}, 32'h1, "irq held");
    @(posedge clk_in);
    trip_pin_n <= 1'b1;
    wr(OFS_ICLR, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1;
    chk({31'h0, irq_out}, 32'h0, "irq clear");
    $display("test trip done");
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    stage_clr <= 1'b0;
    t_reset();
    t_regs();
    t_setup();
    t_shadow();
    t_modes();
    t_scale();
    t_trip();
    test_done();
  end
endmodule // tb_top
